/* File: hw/sysbus_master.sv */
/*
  Backplane bus master: memory and I/O transfers with byte steering, and the
  bus-vectored interrupt acknowledge sequence, ordered by software over APB.
  Assumes slaves hold acknowledge until the command is removed; all backplane
  inputs are asynchronous and are synchronised here.
*/
// Our own choices: the address map and the APB register port.
`timescale 1ns/1ps
module sysbus_master (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Backplane address and control
  output logic [19:0] address_lines_n,
  output logic ctl_oe,
  output logic byte_high_enable_n,
  output logic mem_read_cmd_n,
  output logic mem_write_cmd_n,
  output logic io_read_cmd_n,
  output logic io_write_cmd_n,
  output logic interrupt_ack_cmd_n,
  output logic bus_lock_n,
  // Backplane data, two-way
  output logic [15:0] data_lines_n_out,
  output logic [1:0] data_lines_oe,
  input wire logic [15:0] data_lines_n_in,
  // Backplane responses
  input wire logic transfer_ack_n,
  input wire logic memory_inhibit_n,
  input wire logic [7:0] interrupt_request_lines_n
);
  typedef enum logic [1:0] {S_IDLE, S_SETUP, S_ACTIVE, S_RECOVER} state_t;

  // Pin synchronisers
  logic [25:0] sync1_ff, sync2_ff;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1_ff <= 26'h3ffffff;
      sync2_ff <= 26'h3ffffff;
    end else begin
      sync1_ff <= {data_lines_n_in, transfer_ack_n, memory_inhibit_n, interrupt_request_lines_n};
      sync2_ff <= sync1_ff;
    end
  end
  logic [15:0] data_s;
  logic ack_s, inh_s;
  logic [7:0] req_s;
  assign data_s = sync2_ff[25:10];
  assign ack_s = ~sync2_ff[9];
  assign inh_s = ~sync2_ff[8];
  assign req_s = ~sync2_ff[7:0];

  // APB registers
  logic [5:0] ctrl_ff, nxt_ctrl;
  logic [19:0] addr_ff, nxt_addr;
  logic [15:0] wdata_ff, nxt_wdata;
  logic [31:0] prdata_ff, nxt_prdata;
  logic pready_ff, nxt_pready, pslverr_ff, nxt_pslverr;
  // Engine registers
  state_t state_ff, nxt_state;
  logic [4:0] cnt_ff, nxt_cnt;
  logic [1:0] step_ff, nxt_step;
  logic [15:0] rdata_ff, nxt_rdata, vec_ff, nxt_vec;
  logic done_ff, nxt_done, inh_ff, nxt_inh;
  logic [7:0] frz_ff, nxt_frz;
  logic [2:0] code_ff, nxt_code;
  logic [19:0] adr_pin_ff, nxt_adr_pin;
  logic [15:0] dout_ff, nxt_dout;
  logic [1:0] doe_ff, nxt_doe;
  logic [4:0] cmd_ff, nxt_cmd;
  logic byte_high_enable_n_ff, nxt_byte_high_enable_n, oe_ff, nxt_oe, lock_ff, nxt_lock;

  logic setup_ph, acc_wr, mapped, start, done_clr, busy;
  logic [2:0] op;
  logic is_interrupt_ack_cmd_n, is_wr, split, cur_word;
  logic [1:0] last_step;
  logic [19:0] cur_addr;
  steer_if sif ();

  lane_steer u_steer (.sif(sif));

  assign op = ctrl_ff[2:0];
  assign busy = (state_ff != S_IDLE);
  assign setup_ph = psel && !penable;
  assign acc_wr = psel && penable && pready_ff && pwrite;
  assign mapped = (paddr == sysbus_pkg::OFF_CTRL) || (paddr == sysbus_pkg::OFF_ADDR) ||
                  (paddr == sysbus_pkg::OFF_WDATA) || (paddr == sysbus_pkg::OFF_RDATA) ||
                  (paddr == sysbus_pkg::OFF_STATUS) || (paddr == sysbus_pkg::OFF_VECTOR);
  assign start = acc_wr && (paddr == sysbus_pkg::OFF_CTRL) && pwdata[sysbus_pkg::CTRL_START] && !busy;
  assign done_clr = acc_wr && (paddr == sysbus_pkg::OFF_STATUS) && pwdata[sysbus_pkg::STAT_DONE];

  always_comb begin
    nxt_ctrl = ctrl_ff;
    nxt_addr = addr_ff;
    nxt_wdata = wdata_ff;
    nxt_prdata = prdata_ff;
    nxt_pready = setup_ph;
    nxt_pslverr = setup_ph && !mapped;
    if (setup_ph) begin
      case (paddr)
        sysbus_pkg::OFF_CTRL: nxt_prdata = {25'h0, ctrl_ff, 1'b0};
        sysbus_pkg::OFF_ADDR: nxt_prdata = {12'h0, addr_ff};
        sysbus_pkg::OFF_WDATA: nxt_prdata = {16'h0, wdata_ff};
        sysbus_pkg::OFF_RDATA: nxt_prdata = {16'h0, rdata_ff};
        sysbus_pkg::OFF_STATUS: nxt_prdata = {13'h0, code_ff, req_s, 5'h0, inh_ff, done_ff, busy};
        sysbus_pkg::OFF_VECTOR: nxt_prdata = {16'h0, vec_ff};
        default: nxt_prdata = 32'h0;
      endcase
    end
    // Order fields are frozen while a transfer runs
    if (acc_wr && !busy) begin
      case (paddr)
        sysbus_pkg::OFF_CTRL: nxt_ctrl = pwdata[sysbus_pkg::CTRL_THREE:sysbus_pkg::CTRL_OP_LSB];
        sysbus_pkg::OFF_ADDR: nxt_addr = pwdata[19:0];
        sysbus_pkg::OFF_WDATA: nxt_wdata = pwdata[15:0];
        default: ;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_ff <= sysbus_pkg::CTRL_RST;
      addr_ff <= sysbus_pkg::ADDR_RST;
      wdata_ff <= sysbus_pkg::DATA_RST;
      prdata_ff <= 32'h0;
      pready_ff <= 1'b0;
      pslverr_ff <= 1'b0;
    end else begin
      ctrl_ff <= nxt_ctrl;
      addr_ff <= nxt_addr;
      wdata_ff <= nxt_wdata;
      prdata_ff <= nxt_prdata;
      pready_ff <= nxt_pready;
      pslverr_ff <= nxt_pslverr;
    end
  end

  // Per-step transfer shape; use nxt_ctrl so the launch step sees fresh orders
  logic [5:0] cfg;
  assign cfg = start ? nxt_ctrl : ctrl_ff;
  assign is_interrupt_ack_cmd_n = (cfg[2:0] == sysbus_pkg::OP_INTERRUPT_ACK_CMD_N);
  assign is_wr = (cfg[2:0] == sysbus_pkg::OP_MEM_WR) || (cfg[2:0] == sysbus_pkg::OP_IO_WR);
  assign split = cfg[sysbus_pkg::CTRL_WORD - 1] && (addr_ff[0] || cfg[sysbus_pkg::CTRL_NARROW - 1]);
  assign cur_word = cfg[sysbus_pkg::CTRL_WORD - 1] && !split && !is_interrupt_ack_cmd_n;
  assign last_step = is_interrupt_ack_cmd_n ? (cfg[sysbus_pkg::CTRL_THREE - 1] ? 2'h2 : 2'h1) : (split ? 2'h1 : 2'h0);
  assign cur_addr = addr_ff + {19'h0, nxt_step[0] & split};
  assign sif.word = cur_word;
  assign sif.wdata = cur_word ? wdata_ff : {8'h00, (split && nxt_step[0]) ? wdata_ff[15:8] : wdata_ff[7:0]};
  assign sif.lanes_in = data_s;
  assign sif.req_act = frz_ff;

  always_comb begin
    nxt_state = state_ff;
    nxt_cnt = cnt_ff;
    nxt_step = step_ff;
    nxt_rdata = rdata_ff;
    nxt_vec = vec_ff;
    nxt_inh = inh_ff;
    nxt_frz = frz_ff;
    nxt_code = code_ff;
    nxt_adr_pin = adr_pin_ff;
    nxt_dout = dout_ff;
    nxt_doe = doe_ff;
    nxt_cmd = cmd_ff;
    nxt_byte_high_enable_n = byte_high_enable_n_ff;
    nxt_oe = oe_ff;
    nxt_lock = lock_ff;
    nxt_done = done_ff && !done_clr;
    case (state_ff)
      S_IDLE: begin
        nxt_step = 2'h0;
        if (start) begin
          nxt_state = S_SETUP;
          nxt_cnt = 5'h0;
          nxt_inh = 1'b0;
          nxt_oe = 1'b1;
          nxt_lock = is_interrupt_ack_cmd_n;
        end
      end
      S_SETUP: begin
        nxt_cnt = cnt_ff + 5'h1;
        if (cnt_ff == 5'(sysbus_pkg::SETUP_CYC - 1)) begin
          nxt_state = S_ACTIVE;
          nxt_cnt = 5'h0;
          case (op)
            sysbus_pkg::OP_MEM_RD: nxt_cmd = 5'b11110;
            sysbus_pkg::OP_MEM_WR: nxt_cmd = 5'b11101;
            sysbus_pkg::OP_IO_RD: nxt_cmd = 5'b11011;
            sysbus_pkg::OP_IO_WR: nxt_cmd = 5'b10111;
            default: nxt_cmd = 5'b01111;
          endcase
          if (is_interrupt_ack_cmd_n && step_ff == 2'h0) begin
            nxt_frz = req_s;
          end
        end
      end
      S_ACTIVE: begin
        if (inh_s) begin
          nxt_inh = 1'b1;
        end
        if (cnt_ff != 5'(sysbus_pkg::CMD_CYC - 1)) begin
          nxt_cnt = cnt_ff + 5'h1;
        end else if (ack_s) begin
          // Command drops; write data and address stay up through recovery
          nxt_state = S_RECOVER;
          nxt_cnt = 5'h0;
          nxt_cmd = 5'h1f;
          if (is_interrupt_ack_cmd_n) begin
            if (step_ff == 2'h0) begin
              nxt_code = sif.code;
            end else if (step_ff == 2'h1) begin
              nxt_vec = {8'h00, sif.rd_val[7:0]};
            end else begin
              nxt_vec = {sif.rd_val[7:0], vec_ff[7:0]};
            end
          end else if (!is_wr) begin
            if (cur_word) begin
              nxt_rdata = sif.rd_val;
            end else if (split && step_ff[0]) begin
              nxt_rdata = {sif.rd_val[7:0], rdata_ff[7:0]};
            end else begin
              nxt_rdata = {8'h00, sif.rd_val[7:0]};
            end
          end
        end
      end
      S_RECOVER: begin
        if (cnt_ff != 5'(sysbus_pkg::HOLD_CYC - 1)) begin
          nxt_cnt = cnt_ff + 5'h1;
        end else if (!ack_s) begin
          // Slave keeps acknowledge up until it sees the command gone
          nxt_cnt = 5'h0;
          if (step_ff == last_step) begin
            nxt_state = S_IDLE;
            nxt_oe = 1'b0;
            nxt_doe = 2'h0;
            nxt_lock = 1'b0;
            nxt_done = 1'b1;
          end else begin
            nxt_state = S_SETUP;
            nxt_step = step_ff + 2'h1;
          end
        end
      end
      default: nxt_state = S_IDLE;
    endcase
    // Address and write data are loaded on the same edge
    if (nxt_state == S_SETUP && state_ff != S_SETUP) begin
      if (is_interrupt_ack_cmd_n) begin
        nxt_adr_pin = ~((nxt_step == 2'h0) ? 20'h0 : (20'(nxt_code) << sysbus_pkg::CODE_LSB));
        nxt_doe = 2'h0;
        nxt_byte_high_enable_n = 1'b1;
      end else begin
        nxt_adr_pin = ~cur_addr;
        nxt_dout = sif.lanes_out;
        nxt_doe = is_wr ? sif.lane_oe : 2'h0;
        nxt_byte_high_enable_n = ~sif.byte_high_enable_n_act;
      end
    end
    if (nxt_done && !done_ff) begin
      nxt_done = 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_ff <= S_IDLE;
      cnt_ff <= 5'h0;
      step_ff <= 2'h0;
      rdata_ff <= sysbus_pkg::DATA_RST;
      vec_ff <= sysbus_pkg::DATA_RST;
      done_ff <= 1'b0;
      inh_ff <= 1'b0;
      frz_ff <= 8'h00;
      code_ff <= 3'h0;
      adr_pin_ff <= 20'hfffff;
      dout_ff <= 16'hffff;
      doe_ff <= 2'h0;
      cmd_ff <= 5'h1f;
      byte_high_enable_n_ff <= 1'b1;
      oe_ff <= 1'b0;
      lock_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      cnt_ff <= nxt_cnt;
      step_ff <= nxt_step;
      rdata_ff <= nxt_rdata;
      vec_ff <= nxt_vec;
      done_ff <= nxt_done;
      inh_ff <= nxt_inh;
      frz_ff <= nxt_frz;
      code_ff <= nxt_code;
      adr_pin_ff <= nxt_adr_pin;
      dout_ff <= nxt_dout;
      doe_ff <= nxt_doe;
      cmd_ff <= nxt_cmd;
      byte_high_enable_n_ff <= nxt_byte_high_enable_n;
      oe_ff <= nxt_oe;
      lock_ff <= nxt_lock;
    end
  end

  assign prdata = prdata_ff;
  assign pready = pready_ff;
  assign pslverr = pslverr_ff;
  assign address_lines_n = adr_pin_ff;
  assign ctl_oe = oe_ff;
  assign byte_high_enable_n = byte_high_enable_n_ff;
  assign mem_read_cmd_n = cmd_ff[0];
  assign mem_write_cmd_n = cmd_ff[1];
  assign io_read_cmd_n = cmd_ff[2];
  assign io_write_cmd_n = cmd_ff[3];
  assign interrupt_ack_cmd_n = cmd_ff[4];
  assign bus_lock_n = ~lock_ff;
  assign data_lines_n_out = dout_ff;
  assign data_lines_oe = doe_ff;

  // Checks
  logic any_cmd, wr_cmd;
  assign any_cmd = ~&cmd_ff;
  assign wr_cmd = ~cmd_ff[1] | ~cmd_ff[3];
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  wdata_with_addr_a: assert property ($rose(wr_cmd) |-> data_lines_oe != 2'h0 &&
    $past(data_lines_n_out, 9) == data_lines_n_out && $past(data_lines_oe, 9) == data_lines_oe)
    else $error("write data not presented with address");
  addr_setup_a: assert property ($rose(any_cmd) |-> $past(ctl_oe, 9) &&
    $past(address_lines_n, 9) == address_lines_n)
    else $error("command started before address setup");
  odd_word_split_a: assert property (any_cmd && !ctrl_ff[2] && ctrl_ff[3] && addr_ff[0] |->
    byte_high_enable_n && data_lines_oe != 2'h3)
    else $error("odd word not split into bytes");
  narrow_byte_a: assert property (any_cmd && ctrl_ff[4] |-> byte_high_enable_n && !data_lines_oe[1])
    else $error("narrow master used high lines");
  even_byte_a: assert property (wr_cmd && byte_high_enable_n |-> data_lines_oe == 2'h1 &&
    data_lines_n_out[15:8] == 8'hff)
    else $error("byte not on low lines");
  swap_byte_a: assert property (wr_cmd && !address_lines_n[0] |-> byte_high_enable_n &&
    data_lines_oe == 2'h1)
    else $error("odd byte not swapped onto low lines");
  word_lanes_a: assert property (wr_cmd && !byte_high_enable_n |-> data_lines_oe == 2'h3 &&
    address_lines_n[0])
    else $error("word not on both byte lanes");
  no_odd_high_a: assert property (ctl_oe && !byte_high_enable_n |-> address_lines_n[0])
    else $error("byte high enable with odd address");
  ack_freeze_a: assert property ($fell(interrupt_ack_cmd_n) && step_ff == 2'h0 |->
    frz_ff == $past(req_s))
    else $error("request state not frozen at first acknowledge");
  interrupt_ack_cmd_n_lock_a: assert property (!interrupt_ack_cmd_n || (busy && op == sysbus_pkg::OP_INTERRUPT_ACK_CMD_N) |-> !bus_lock_n)
    else $error("bus not locked during acknowledge sequence");
  code_lines_a: assert property (!interrupt_ack_cmd_n && step_ff != 2'h0 |->
    ~address_lines_n[10:8] == code_ff)
    else $error("interrupt code missing on address lines");
  prio_lowest_a: assert property ($rose(interrupt_ack_cmd_n) && step_ff == 2'h0 && frz_ff != 8'h00 ##1 1'b1 |->
    frz_ff[code_ff] && (frz_ff & ((8'h01 << code_ff) - 8'h01)) == 8'h00)
    else $error("code is not the highest priority request");
endmodule

/* File: hw/sysbus_pkg.sv */
/*
  Constants shared by the backplane master controller and its bench; the lane steering helper uses none.
  Assumes a 200 MHz pclk; all backplane timing is counted in pclk cycles.
*/
package sysbus_pkg;
  // Clock and backplane timing
  localparam int CLK_MHZ = 200;
  localparam int ADDR_SETUP_NS = 50;
  localparam int ADDR_HOLD_NS = 50;
  localparam int CMD_WIDTH_NS = 100;
  localparam int SETUP_CYC = (ADDR_SETUP_NS * CLK_MHZ + 999) / 1000;
  localparam int HOLD_CYC = (ADDR_HOLD_NS * CLK_MHZ + 999) / 1000;
  localparam int CMD_CYC = (CMD_WIDTH_NS * CLK_MHZ + 999) / 1000;

  // Register offsets
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_ADDR = 8'h04;
  localparam logic [7:0] OFF_WDATA = 8'h08;
  localparam logic [7:0] OFF_RDATA = 8'h0c;
  localparam logic [7:0] OFF_STATUS = 8'h10;
  localparam logic [7:0] OFF_VECTOR = 8'h14;

  // Control fields
  localparam int CTRL_START = 0;
  localparam int CTRL_OP_LSB = 1;
  localparam int CTRL_WORD = 4;
  localparam int CTRL_NARROW = 5;
  localparam int CTRL_THREE = 6;

  // Status fields
  localparam int STAT_BUSY = 0;
  localparam int STAT_DONE = 1;
  localparam int STAT_INH = 2;
  localparam int STAT_REQ_LSB = 8;
  localparam int STAT_CODE_LSB = 16;

  // Interrupt code position on the address lines
  localparam int CODE_LSB = 8;

  // Reset values
  localparam logic [5:0] CTRL_RST = 6'h00;
  localparam logic [19:0] ADDR_RST = 20'h00000;
  localparam logic [15:0] DATA_RST = 16'h0000;

  typedef enum logic [2:0] {
    OP_MEM_RD = 3'h0,
    OP_MEM_WR = 3'h1,
    OP_IO_RD = 3'h2,
    OP_IO_WR = 3'h3,
    OP_INTERRUPT_ACK_CMD_N = 3'h4
  } op_t;
endpackage

/* File: hw/steer_if.sv */
/*
  Bundle between the master controller and its lane steering helper.
  Assumes both ends sit in the pclk domain; the bundle is purely combinational.
*/
`timescale 1ns/1ps
interface steer_if;
  logic word;
  logic [15:0] wdata;
  logic [15:0] lanes_out;
  logic [1:0] lane_oe;
  logic byte_high_enable_n_act;
  logic [15:0] lanes_in;
  logic [15:0] rd_val;
  logic [7:0] req_act;
  logic [2:0] code;
  logic req_any;

  modport ctrl (output word, wdata, lanes_in, req_act,
                input lanes_out, lane_oe, byte_high_enable_n_act, rd_val, code, req_any);
  modport steer (input word, wdata, lanes_in, req_act,
                 output lanes_out, lane_oe, byte_high_enable_n_act, rd_val, code, req_any);
endinterface

/* File: hw/lane_steer.sv */
/*
  Byte lane steering and interrupt priority encoding for the backplane master.
  Assumes lanes_in is already synchronised; pins are active low.
*/
`timescale 1ns/1ps
module lane_steer (
  // Controller side
  steer_if.steer sif
);
  always_comb begin
    if (sif.word) begin
      // Even byte on low lines, odd byte on high lines
      sif.lanes_out = ~sif.wdata;
      sif.lane_oe = 2'h3;
      sif.byte_high_enable_n_act = 1'b1;
      sif.rd_val = ~sif.lanes_in;
    end else begin
      // Any single byte, even or swapped odd, rides the low lines
      sif.lanes_out = {8'hff, ~sif.wdata[7:0]};
      sif.lane_oe = 2'h1;
      sif.byte_high_enable_n_act = 1'b0;
      sif.rd_val = {8'h00, ~sif.lanes_in[7:0]};
    end
  end

  // Line zero wins over all others
  always_comb begin
    sif.code = 3'h0;
    sif.req_any = 1'b0;
    for (int i = 7; i >= 0; i--) begin
      if (sif.req_act[i]) begin
        sif.code = 3'(i);
        sif.req_any = 1'b1;
      end
    end
  end
endmodule

/* File: bench/sysbus_slave_model.sv */
/*
  Slave boards on the backplane: 16-bit memory with a swap lane, an overriding
  board that inhibits it, and a bus-vectored interrupt controller.
  Assumes the bench resolves the data lines with pull-ups and drives the requests.
*/
`timescale 1ns/1ps
module sysbus_slave_model #(
  parameter logic [15:0] ROM_WORD = 16'hc3a5,
  parameter int INH_EXTRA = 30
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // From the master, plus the request lines from the bench
  input wire logic [19:0] address_lines_n,
  input wire logic ctl_oe,
  input wire logic byte_high_enable_n,
  input wire logic [4:0] cmd_n,
  input wire logic bus_lock_n,
  input wire logic [15:0] data_lines_n,
  input wire logic [7:0] interrupt_request_lines_n,
  // Bench controls
  input wire logic [7:0] ack_dly,
  input wire logic inh_en,
  // Slave drive
  output logic transfer_ack_n,
  output logic memory_inhibit_n,
  output logic [15:0] slave_data_n,
  output logic [1:0] slave_oe,
  // Observation
  output int err_cnt,
  output int cmd_cnt,
  output int byte_high_enable_n_cnt
);
  logic [15:0] mem [0:255];
  logic [19:0] a, a_q;
  logic bh, rd, wr, ia, cmd, cmd_q, wr_q, oe_q;
  logic [15:0] d_oe, d_lead, d;
  logic [7:0] frozen;
  logic [2:0] pri;
  int cnt, step;
  assign a = ~address_lines_n;
  assign d = ~data_lines_n;
  assign bh = ~byte_high_enable_n;
  assign rd = ~cmd_n[4] | ~cmd_n[2];
  assign wr = ~cmd_n[3] | ~cmd_n[1];
  assign ia = ~cmd_n[0];
  assign cmd = rd | wr | ia;
  always_comb begin
    pri = 3'h0;
    for (int i = 7; i >= 0; i--) begin
      if (frozen[i]) pri = i[2:0];
    end
  end
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < 256; i++) mem[i] <= 16'h0000;
      {cmd_q, wr_q, oe_q, frozen, a_q, d_oe, d_lead} <= '0;
      {cnt, step, err_cnt, cmd_cnt, byte_high_enable_n_cnt} <= '0;
      {transfer_ack_n, memory_inhibit_n, slave_oe, slave_data_n} <= {2'b11, 2'b00, 16'hffff};
    end else begin
      {cmd_q, wr_q, oe_q, a_q} <= {cmd, wr, ctl_oe, address_lines_n};
      memory_inhibit_n <= ~(inh_en & ctl_oe);
      // Data seen when the address first becomes stable
      if (ctl_oe & (~oe_q | (address_lines_n != a_q))) d_oe <= d;
      if (bus_lock_n & ~cmd) step <= 0;
      if (cmd & ~cmd_q) begin
        cmd_cnt <= cmd_cnt + 1;
        cnt <= 0;
        d_lead <= d;
        if (bh) byte_high_enable_n_cnt <= byte_high_enable_n_cnt + 1;
        if ((bh & a[0]) | (wr & (d_oe !== d)) | (ia & bus_lock_n) | (ia & (step != 0) & (a[10:8] != pri)))
          err_cnt <= err_cnt + 1;
        if (ia) step <= step + 1;
        if (ia & (step == 0)) frozen <= ~interrupt_request_lines_n;
      end else if (cmd) cnt <= cnt + 1;
      if (cmd & cmd_q & rd) begin
        slave_oe <= bh ? 2'b11 : 2'b01;
        slave_data_n <= ~(inh_en ? ROM_WORD : (bh | ~a[0]) ? mem[a[8:1]] : {8'h00, mem[a[8:1]][15:8]});
      end else if (cmd & cmd_q & ia & (step > 1)) begin
        slave_oe <= 2'b01;
        slave_data_n <= {8'hff, ~(((step == 2) ? 8'h40 : 8'ha0) | {5'h00, a[10:8]})};
      end
      if (cmd & cmd_q & (cnt >= ack_dly + (inh_en ? INH_EXTRA : 0))) transfer_ack_n <= 1'b0;
      if (~cmd & cmd_q) begin
        transfer_ack_n <= 1'b1;
        slave_oe <= 2'b00;
        if (wr_q & (d_lead !== d)) err_cnt <= err_cnt + 1;
        // Inhibited RAM keeps its contents
        if (wr_q & ~inh_en & ~bh & ~a[0]) mem[a[8:1]][7:0] <= d[7:0];
        if (wr_q & ~inh_en & ~bh & a[0]) mem[a[8:1]][15:8] <= d[7:0];
        if (wr_q & ~inh_en & bh & ~a[0]) mem[a[8:1]] <= d;
      end
    end
  end
endmodule

/* File: bench/sysbus_byte_steer_inhibit_irq_tb.sv */
/*
  Self-checking bench for the backplane master, driven over APB.
  Assumes the slave model on the far side and pull-ups on the data lines.
*/
`timescale 1ns/1ps
module sysbus_byte_steer_inhibit_irq_tb;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, q, st;
  logic pready, pslverr, ctl_oe, byte_high_enable_n, bus_lock_n, e;
  logic mem_read_cmd_n, mem_write_cmd_n, io_read_cmd_n, io_write_cmd_n, interrupt_ack_cmd_n;
  logic [19:0] address_lines_n;
  logic [15:0] data_lines_n_out, data_lines_n_in, slave_data_n;
  logic [1:0] data_lines_oe, slave_oe;
  logic transfer_ack_n, memory_inhibit_n;
  logic [7:0] interrupt_request_lines_n = 8'hff;
  logic [7:0] ack_dly = 8'd3;
  logic inh_en = 1'b0;
  int n_mismatch = 0, total_checks = 0, cycles = 0, n0, n1, err_cnt, cmd_cnt, byte_high_enable_n_cnt;
  always #2.5 pclk = ~pclk;
  // Wire level: master, then slave, else pull-up
  assign data_lines_n_in[7:0] = data_lines_oe[0] ? data_lines_n_out[7:0] : slave_oe[0] ? slave_data_n[7:0] : 8'hff;
  assign data_lines_n_in[15:8] = data_lines_oe[1] ? data_lines_n_out[15:8] : slave_oe[1] ? slave_data_n[15:8] : 8'hff;
  sysbus_master dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .address_lines_n(address_lines_n), .ctl_oe(ctl_oe), .byte_high_enable_n(byte_high_enable_n),
    .mem_read_cmd_n(mem_read_cmd_n), .mem_write_cmd_n(mem_write_cmd_n), .io_read_cmd_n(io_read_cmd_n),
    .io_write_cmd_n(io_write_cmd_n), .interrupt_ack_cmd_n(interrupt_ack_cmd_n), .bus_lock_n(bus_lock_n),
    .data_lines_n_out(data_lines_n_out), .data_lines_oe(data_lines_oe), .data_lines_n_in(data_lines_n_in),
    .transfer_ack_n(transfer_ack_n), .memory_inhibit_n(memory_inhibit_n),
    .interrupt_request_lines_n(interrupt_request_lines_n));
  sysbus_slave_model slave (.pclk(pclk), .presetn(presetn), .address_lines_n(address_lines_n), .ctl_oe(ctl_oe),
    .byte_high_enable_n(byte_high_enable_n), .bus_lock_n(bus_lock_n), .data_lines_n(data_lines_n_in),
    .cmd_n({mem_read_cmd_n, mem_write_cmd_n, io_read_cmd_n, io_write_cmd_n, interrupt_ack_cmd_n}),
    .interrupt_request_lines_n(interrupt_request_lines_n), .ack_dly(ack_dly), .inh_en(inh_en),
    .transfer_ack_n(transfer_ack_n), .memory_inhibit_n(memory_inhibit_n), .slave_data_n(slave_data_n),
    .slave_oe(slave_oe), .err_cnt(err_cnt), .cmd_cnt(cmd_cnt), .byte_high_enable_n_cnt(byte_high_enable_n_cnt));
  task automatic conclude();
    $display("Checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  always @(posedge pclk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      n_mismatch++;
      conclude();
    end
  end
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r,
                     output logic er);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    r = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic er;
    apb(1'b1, a, d, r, er);
  endtask
  task automatic rdchk(input string nm, input logic [7:0] a, input logic [31:0] m, input logic [31:0] x);
    logic er;
    apb(1'b0, a, 32'h0, q, er);
    chk(nm, x, q & m);
  endtask
  // One command through the backplane, waiting for done
  task automatic run(input sysbus_pkg::op_t op, input logic [2:0] fl, input logic [19:0] a, input logic [15:0] d);
    wr(sysbus_pkg::OFF_ADDR, {12'h000, a});
    wr(sysbus_pkg::OFF_WDATA, {16'h0000, d});
    wr(sysbus_pkg::OFF_CTRL, {25'h0, fl, op, 1'b1});
    st = 32'h0;
    while (st[sysbus_pkg::STAT_DONE] !== 1'b1) apb(1'b0, sysbus_pkg::OFF_STATUS, 32'h0, st, e);
    wr(sysbus_pkg::OFF_STATUS, 32'h2);
  endtask
  initial begin
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    chk("address_idle", 32'h000fffff, {12'h000, address_lines_n});
    chk("drive_idle", 32'h0, {29'h0, ctl_oe, data_lines_oe});
    chk("lock_idle", 32'h1, {31'h0, bus_lock_n});
    run(sysbus_pkg::OP_MEM_WR, 3'b001, 20'h00100, 16'h1234);
    chk("mem_even_word", 32'h1234, slave.mem[8'h80]);
    run(sysbus_pkg::OP_MEM_WR, 3'b000, 20'h00102, 16'h00cd);
    run(sysbus_pkg::OP_MEM_WR, 3'b000, 20'h00103, 16'h00ab);
    chk("mem_bytes", 32'habcd, slave.mem[8'h81]);
    run(sysbus_pkg::OP_MEM_RD, 3'b001, 20'h00102, 16'h0000);
    rdchk("rd_word", sysbus_pkg::OFF_RDATA, 32'hffff, 32'habcd);
    run(sysbus_pkg::OP_MEM_RD, 3'b000, 20'h00103, 16'h0000);
    rdchk("rd_odd_byte", sysbus_pkg::OFF_RDATA, 32'hff, 32'hab);
    n0 = cmd_cnt;
    run(sysbus_pkg::OP_MEM_WR, 3'b001, 20'h00105, 16'h5678);
    chk("odd_word_steps", 32'd2, cmd_cnt - n0);
    chk("odd_word_mem", 32'h00567800, {slave.mem[8'h83], slave.mem[8'h82]});
    run(sysbus_pkg::OP_MEM_RD, 3'b001, 20'h00105, 16'h0000);
    rdchk("rd_odd_word", sysbus_pkg::OFF_RDATA, 32'hffff, 32'h5678);
    n0 = cmd_cnt;
    n1 = byte_high_enable_n_cnt;
    run(sysbus_pkg::OP_MEM_WR, 3'b011, 20'h00108, 16'h9abc);
    chk("narrow_steps", 32'd2, cmd_cnt - n0);
    chk("narrow_byte_high_enable_n", n1, byte_high_enable_n_cnt);
    chk("narrow_mem", 32'h9abc, slave.mem[8'h84]);
    run(sysbus_pkg::OP_IO_WR, 3'b001, 20'h00010, 16'h0f0f);
    run(sysbus_pkg::OP_IO_RD, 3'b001, 20'h00010, 16'h0000);
    rdchk("io_word", sysbus_pkg::OFF_RDATA, 32'hffff, 32'h0f0f);
    ack_dly <= 8'd60;
    run(sysbus_pkg::OP_MEM_RD, 3'b001, 20'h00100, 16'h0000);
    ack_dly <= 8'd3;
    rdchk("slow_ack", sysbus_pkg::OFF_RDATA, 32'hffff, 32'h1234);
    inh_en <= 1'b1;
    run(sysbus_pkg::OP_MEM_WR, 3'b001, 20'h00100, 16'h7777);
    chk("inh_seen", 32'h1, st[sysbus_pkg::STAT_INH]);
    chk("inh_mem", 32'h1234, slave.mem[8'h80]);
    run(sysbus_pkg::OP_MEM_RD, 3'b001, 20'h00100, 16'h0000);
    rdchk("inh_rd", sysbus_pkg::OFF_RDATA, 32'hffff, 32'hc3a5);
    inh_en <= 1'b0;
    run(sysbus_pkg::OP_MEM_RD, 3'b001, 20'h00100, 16'h0000);
    chk("inh_clear", 32'h0, st[sysbus_pkg::STAT_INH]);
    rdchk("ram_back", sysbus_pkg::OFF_RDATA, 32'hffff, 32'h1234);
    interrupt_request_lines_n <= 8'hd7;
    run(sysbus_pkg::OP_INTERRUPT_ACK_CMD_N, 3'b000, 20'h00000, 16'h0000);
    chk("req_status", 32'h28, st[15:8]);
    chk("code_status", 32'h3, st[18:16]);
    rdchk("vector_two", sysbus_pkg::OFF_VECTOR, 32'hff, 32'h43);
    interrupt_request_lines_n <= 8'h7f;
    run(sysbus_pkg::OP_INTERRUPT_ACK_CMD_N, 3'b100, 20'h00000, 16'h0000);
    rdchk("vector_three", sysbus_pkg::OFF_VECTOR, 32'hffff, 32'ha747);
    interrupt_request_lines_n <= 8'hff;
    apb(1'b0, 8'h20, 32'h0, q, e);
    chk("unmapped_err", 32'h1, e);
    chk("unmapped_data", 32'h0, q);
    chk("model_errors", 32'h0, err_cnt);
    conclude();
  end
endmodule
